// *** core/fpc_arith_ctrl.sv ***
// Contract
// (RULE_01) Control word holds integer-overflow flag at bit 8, its mask at bit 12.
// (RULE_02) Floating flags: overflow 16, underflow 17, invalid 18, zero-divide 19, inexact 20.
// (RULE_03) Floating masks: overflow 24, underflow 25, invalid 26, zero-divide 27, inexact 28.
// (RULE_04) Bit 29 selects normalizing mode; bits 30-31 select rounding mode.
// (RULE_05) Normalizing mode processes denormal sources like any valid operand.
// (RULE_06) Without normalizing mode a denormal source raises reserved-encoding exception.
// (RULE_07) Reserved-encoding always faults, has no flag or mask, destination not written.
// (RULE_08) Denormal results are delivered in either mode when underflow is masked.
// (RULE_09) Any result that must be rounded sets the inexact flag.
// (RULE_10) Round to destination precision using the selected of four modes.
// (RULE_11) Nearest mode breaks exact ties toward the even value.
// (RULE_12) Positive overflow: infinity in up/nearest, max finite in down/zero.
// (RULE_13) Negative overflow: minus infinity in down/nearest, max negative finite otherwise.
// (RULE_14) Rounding mode does not touch compares, exact results or NaN results.
// (RULE_15) Narrow destination rounds once from the precise result.
// (RULE_16) Float literals decode only to +0.0 and +1.0.
// (RULE_17) Local, global and the four float registers are all legal operands.
// (RULE_18) Opcode picks 32-bit or 64-bit view of general registers.
// (RULE_19) Float registers mix with either precision; single and double never mix.
// (RULE_20) All float instructions decode from the register three-operand format.
// (RULE_21) A set mask blocks the fault while the flag still records it.
// (RULE_22) Rounding selector: 00 nearest, 01 down, 10 up, 11 toward zero.
`timescale 1ns/1ps
module fpc_arith_ctrl
  import fpc_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic decValid,
  input wire logic [31:0] decWord,
  output logic decOutValid,
  output fpc_decode_type decOut,
  input wire logic reqValid,
  input wire fpc_round_req_type req,
  output logic rspValid,
  output fpc_round_rsp_type rsp,
  input wire logic intOvfEvt,
  output logic intFault,
  output logic [31:0] acwOut
);

  if (ADDR_W < 3 || ADDR_W > 12)
  begin : g_chk
    $error("fpc_arith_ctrl: ADDR_W must lie in 3..12");
  end

  logic [31:0] acw_r;
  logic [31:0] acw_nxt;
  fpc_fault_type lastFault_r;

  // Format figures used by the rounder
  function automatic int precOf(fpc_fmt_type f);
    unique case (f)
      FMT_SINGLE: return PREC_SINGLE;
      FMT_DOUBLE: return PREC_DOUBLE;
      default: return PREC_EXT;
    endcase
  endfunction : precOf
  function automatic int emaxOf(fpc_fmt_type f);
    unique case (f)
      FMT_SINGLE: return EMAX_SINGLE;
      FMT_DOUBLE: return EMAX_DOUBLE;
      default: return EMAX_EXT;
    endcase
  endfunction : emaxOf
  // Packs sign, biased exponent and significand into the destination layout
  function automatic logic [79:0] packRes(fpc_fmt_type f, logic sg, logic [14:0] be, logic [63:0] m);
    unique case (f)
      FMT_SINGLE: return {48'h0, sg, be[7:0], m[22:0]};
      FMT_DOUBLE: return {16'h0, sg, be[10:0], m[51:0]};
      default: return {sg, be, m};
    endcase
  endfunction : packRes
  // Extended-form operand with zero exponent and nonzero significand
  function automatic logic isDenorm(logic [79:0] x);
    return (x[78:64] == 15'h0) && (x[63:0] != 64'h0);
  endfunction : isDenorm
  // One operand field: general registers or float space
  function automatic fpc_opnd_type decOpnd(logic [4:0] code, logic fspace, logic isDst);
    fpc_opnd_type o;
    o = '{kind: OPK_LOCAL, idx: code[3:0], constVal: 80'h0, bad: 1'b0};
    if (!fspace)
      o.kind = code[4] ? OPK_GLOBAL : OPK_LOCAL; // RULE_17
    else if (code[4:2] == 3'h0)
      o.kind = OPK_FPREG; // RULE_17
    else if (!isDst && (code == LIT_ZERO_CODE || code == LIT_ONE_CODE))
    begin
      o.kind = OPK_LITERAL; // RULE_16
      o.constVal = (code == LIT_ONE_CODE) ? FP_ONE : 80'h0;
    end
    else
      o.bad = 1'b1;
    return o;
  endfunction : decOpnd

  // Each field decoded once, shared by the stored record and the illegal flag
  fpc_opnd_type opS1, opS2, opD;
  assign opS1 = decOpnd(decWord[INS_SRC1_LO +: 5], decWord[INS_M1], 1'b0); // RULE_20
  assign opS2 = decOpnd(decWord[INS_SRC2_LO +: 5], decWord[INS_M2], 1'b0);
  assign opD = decOpnd(decWord[INS_DST_LO +: 5], decWord[INS_M3], 1'b1);
  // Operand decode, one fixed three-operand layout for every float opcode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decOutValid <= 1'b0;
      decOut <= '0;
    end
    else
    begin
      decOutValid <= decValid;
      if (decValid)
      begin
        decOut.src1 <= opS1; // RULE_20
        decOut.src2 <= opS2;
        decOut.dst <= opD;
        // One precision bit per opcode, so general operands never mix widths
        decOut.genFmt <= decWord[INS_LONG] ? FMT_DOUBLE : FMT_SINGLE; // RULE_18 RULE_19
        decOut.illegal <= opS1.bad | opS2.bad | opD.bad;
      end
    end
  end

  fpc_round_rsp_type rnd;
  fpc_rmode_type rm;
  logic resEnc;

  // Single rounding step straight from the wide precise value
  always_comb
  begin
    int prec;
    int emax;
    int emin;
    int lsb;
    int dsh;
    logic [SIG_W-1:0] s;
    logic [64:0] sum;
    logic signed [18:0] e;
    logic rb;
    logic st;
    logic up;
    logic tiny;
    logic ovf;
    logic inx;
    logic toInf;
    logic [4:0] unm;
    prec = precOf(req.fmt);
    emax = emaxOf(req.fmt);
    emin = 1 - emax;
    lsb = SIG_W - prec;
    dsh = 0;
    up = 1'b0;
    s = req.sig;
    e = req.exp;
    st = req.sticky;
    rm = fpc_rmode_type'(acw_r[ACW_RM_LO +: 2]); // RULE_04 RULE_22
    // Tiny values are shifted to the minimum exponent before rounding
    tiny = (s != '0) && (e < emin);
    if (tiny)
    begin
      dsh = emin - int'(e);
      if (dsh > SIG_W)
        dsh = SIG_W;
      st = st | (|(s & ((67'h1 << dsh) - 67'h1)));
      s = s >> dsh;
      e = 19'(emin);
    end
    rb = s[lsb-1];
    st = st | (|(s & ((67'h1 << (lsb - 1)) - 67'h1))); // RULE_15
    sum = {1'b0, 64'(s >> lsb)};
    inx = rb | st;
    unique case (rm)
      RM_NEAREST: up = rb & (st | sum[0]); // RULE_11
      RM_UP: up = inx & !req.sign;
      RM_DOWN: up = inx & req.sign;
      RM_ZERO: up = 1'b0;
    endcase
    sum = sum + {64'h0, up}; // RULE_10
    if (sum[prec])
    begin
      sum = sum >> 1;
      e = e + 19'sd1;
    end
    ovf = (sum != '0) && (e > emax);
    toInf = req.sign ? (rm == RM_DOWN || rm == RM_NEAREST) : (rm == RM_UP || rm == RM_NEAREST);
    rnd.exc = '0;
    rnd.exc[EXC_INV] = req.invalid;
    rnd.exc[EXC_ZDIV] = req.zeroDiv;
    if (req.isCompare)
      rnd.result = '0; // RULE_14
    else if (req.nanRes || req.invalid)
      rnd.result = packRes(req.fmt, 1'b0, 15'(2 * emax + 1), 64'(64'h3 << (prec - 2))); // RULE_14
    else if (req.zeroDiv)
      rnd.result = packRes(req.fmt, req.sign, 15'(2 * emax + 1), 64'(64'h1 << (prec - 1)));
    else if (ovf)
    begin
      rnd.exc[EXC_OVF] = 1'b1;
      rnd.exc[EXC_INX] = 1'b1;
      if (toInf)
        rnd.result = packRes(req.fmt, req.sign, 15'(2 * emax + 1), 64'(64'h1 << (prec - 1))); // RULE_12 RULE_13
      else
        rnd.result = packRes(req.fmt, req.sign, 15'(2 * emax), 64'((65'h1 << prec) - 65'h1)); // RULE_12 RULE_13
    end
    else
    begin
      rnd.exc[EXC_INX] = inx; // RULE_09
      rnd.exc[EXC_UNF] = tiny & inx;
      // Integer bit clear after rounding means a denormal, biased exponent zero
      rnd.result = packRes(req.fmt, req.sign, sum[prec-1] ? 15'(int'(e) + emax) : 15'h0, sum[63:0]); // RULE_08
    end
    // Unmasked exceptions in priority order
    unm = rnd.exc & ~acw_r[ACW_MASK_LO +: EXC_N];
    resEnc = !acw_r[ACW_NORM] && ((req.srcUsed[0] && isDenorm(req.srcA))
      || (req.srcUsed[1] && isDenorm(req.srcB))); // RULE_05 RULE_06
    if (resEnc)
      rnd.fault = FLT_RESENC; // RULE_07
    else if (unm[EXC_INV])
      rnd.fault = FLT_INVALID; // RULE_21
    else if (unm[EXC_ZDIV])
      rnd.fault = FLT_ZDIV;
    else if (unm[EXC_OVF])
      rnd.fault = FLT_OVF;
    else if (unm[EXC_UNF])
      rnd.fault = FLT_UNF;
    else if (unm[EXC_INX])
      rnd.fault = FLT_INX;
    else
      rnd.fault = FLT_NONE;
    if (resEnc)
      rnd.exc = '0;
    rnd.write = !req.isCompare && (rnd.fault == FLT_NONE); // RULE_07
  end

  // Rounder result register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rspValid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      rspValid <= reqValid;
      if (reqValid)
        rsp <= rnd;
    end
  end

  // Integer overflow fault pulse, suppressed by its mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      intFault <= 1'b0;
    else
      intFault <= intOvfEvt && !acw_r[ACW_INT_OVF_MASK]; // RULE_01 RULE_21
  end

  // Write channel state
  logic awHeld_r, wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic haveAw, haveW, doWrite, bValid_nxt, awHeld_nxt, wHeld_nxt;
  logic [ADDR_W-1:0] wAddr;
  logic [31:0] wDat;
  logic [3:0] wStb;

  always_comb
  begin
    haveAw = awHeld_r || (awvalid && awready);
    haveW = wHeld_r || (wvalid && wready);
    doWrite = haveAw && haveW;
    awHeld_nxt = haveAw && !haveW;
    wHeld_nxt = haveW && !haveAw;
    bValid_nxt = doWrite || (bvalid && !bready);
    wAddr = awHeld_r ? awAddr_r : awaddr;
    wDat = wHeld_r ? wData_r : wdata;
    wStb = wHeld_r ? wStrb_r : wstrb;
  end

  // Address and data may arrive in either order; the answer waits for both
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      if (awvalid && awready)
        awAddr_r <= awaddr;
      if (wvalid && wready)
      begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      awready <= !awHeld_nxt && !bValid_nxt;
      wready <= !wHeld_nxt && !bValid_nxt;
      bvalid <= bValid_nxt;
      if (doWrite)
        bresp <= (wAddr[ADDR_W-1:2] == ADDR_W'(OFF_ACW) >> 2) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Control word next value: software write, then hardware sets on top
  always_comb
  begin
    acw_nxt = acw_r;
    if (doWrite && wAddr[ADDR_W-1:2] == ADDR_W'(OFF_ACW) >> 2)
    begin
      for (int b = 0; b < 4; b++)
        if (wStb[b])
          acw_nxt[8*b +: 8] = wDat[8*b +: 8] & ACW_WMASK[8*b +: 8];
    end
    // A set arriving with a clearing write survives it
    if (intOvfEvt)
      acw_nxt[ACW_INT_OVF_FLAG] = 1'b1; // RULE_01
    if (rspValid)
      acw_nxt[ACW_FLAG_LO +: EXC_N] = acw_nxt[ACW_FLAG_LO +: EXC_N] | rsp.exc; // RULE_02 RULE_21
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acw_r <= ACW_RESET;
    else
      acw_r <= acw_nxt; // RULE_03 RULE_04
  end

  assign acwOut = acw_r;

  // Last fault seen, readable for diagnosis
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lastFault_r <= FLT_NONE;
    else if (rspValid && rsp.fault != FLT_NONE)
      lastFault_r <= rsp.fault;
    else if (intFault)
      lastFault_r <= FLT_INTOVF;
  end

  // Read channel, one read outstanding
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr[ADDR_W-1:2] == ADDR_W'(OFF_ACW) >> 2)
        rdata <= acw_r;
      else if (araddr[ADDR_W-1:2] == ADDR_W'(OFF_FAULT) >> 2)
        rdata <= {29'h0, lastFault_r};
      else
      begin
        rdata <= '0;
        rresp <= RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Helpers that remember the conditions of the last rounding
  fpc_rmode_type rmUsed_r;
  fpc_fmt_type fmtUsed_r;
  logic sgnUsed_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rmUsed_r <= RM_NEAREST;
      fmtUsed_r <= FMT_SINGLE;
      sgnUsed_r <= 1'b0;
    end
    else if (reqValid)
    begin
      rmUsed_r <= rm;
      fmtUsed_r <= req.fmt;
      sgnUsed_r <= req.sign;
    end
  end

  sequence s_denormSrc;
    reqValid && !acw_r[ACW_NORM] && req.srcUsed[0] && isDenorm(req.srcA);
  endsequence

  sequence s_resencOut;
    rspValid && rsp.fault == FLT_RESENC && !rsp.write && rsp.exc == '0;
  endsequence

  a_resenc_fault: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    s_denormSrc |=> s_resencOut) else $error("denormal source did not fault");
  a_norm_accepts: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    reqValid && acw_r[ACW_NORM] |=> rsp.fault != FLT_RESENC) else $error("reserved fault in normalizing mode");
  a_resenc_nowrite: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    rspValid && rsp.fault == FLT_RESENC |-> !rsp.write ##1 $stable(acw_r[ACW_FLAG_LO +: EXC_N]))
    else $error("reserved fault wrote or flagged");
  a_inexact_sets: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    rspValid && rsp.exc[EXC_INX] |=> acw_r[ACW_FLAG_LO + EXC_INX]) else $error("inexact flag not set");
  a_nan_untouched: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    reqValid && (req.nanRes || req.isCompare) && !req.invalid |=> !rsp.exc[EXC_INX])
    else $error("NaN or compare raised inexact");
  a_ovf_positive: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    rspValid && rsp.write && rsp.exc[EXC_OVF] && !sgnUsed_r && fmtUsed_r == FMT_SINGLE
    |-> rsp.result[31:0] == ((rmUsed_r == RM_UP || rmUsed_r == RM_NEAREST) ? 32'h7F80_0000 : 32'h7F7F_FFFF))
    else $error("positive overflow value wrong");
  a_ovf_negative: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    rspValid && rsp.write && rsp.exc[EXC_OVF] && sgnUsed_r && fmtUsed_r == FMT_SINGLE
    |-> rsp.result[31:0] == ((rmUsed_r == RM_DOWN || rmUsed_r == RM_NEAREST) ? 32'hFF80_0000 : 32'hFF7F_FFFF))
    else $error("negative overflow value wrong");
  a_lit_one: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    decValid && decWord[INS_M1] && decWord[INS_SRC1_LO +: 5] == LIT_ONE_CODE
    |=> decOut.src1.kind == OPK_LITERAL && decOut.src1.constVal == FP_ONE) else $error("literal one wrong");
  a_int_ovf: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    intOvfEvt |=> acw_r[ACW_INT_OVF_FLAG] && (intFault == !$past(acw_r[ACW_INT_OVF_MASK])))
    else $error("integer overflow not recorded");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    rspValid && rsp.fault inside {FLT_OVF, FLT_UNF, FLT_INX} |-> !rsp.write) else $error("faulted result written");

endmodule : fpc_arith_ctrl

// *** shared/fpc_pkg.sv ***
package fpc_pkg;

  // Arithmetic control word field positions
  localparam int ACW_INT_OVF_FLAG = 8;
  localparam int ACW_INT_OVF_MASK = 12;
  localparam int ACW_FLAG_LO = 16;
  localparam int ACW_MASK_LO = 24;
  localparam int ACW_NORM = 29;
  localparam int ACW_RM_LO = 30;

  // Exception index within flag and mask fields
  localparam int EXC_OVF = 0;
  localparam int EXC_UNF = 1;
  localparam int EXC_INV = 2;
  localparam int EXC_ZDIV = 3;
  localparam int EXC_INX = 4;
  localparam int EXC_N = 5;

  // Reset value and writable bits of the control word
  localparam logic [31:0] ACW_RESET = 32'h3F00_1000;
  localparam logic [31:0] ACW_WMASK = 32'hFF1F_117F;

  // Register byte offsets
  localparam logic [3:0] OFF_ACW = 4'h0;
  localparam logic [3:0] OFF_FAULT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Instruction word field positions
  localparam int INS_SRC1_LO = 0;
  localparam int INS_LONG = 7;
  localparam int INS_M1 = 11;
  localparam int INS_M2 = 12;
  localparam int INS_M3 = 13;
  localparam int INS_SRC2_LO = 14;
  localparam int INS_DST_LO = 19;
  localparam logic [4:0] LIT_ZERO_CODE = 5'h10;
  localparam logic [4:0] LIT_ONE_CODE = 5'h16;
  localparam logic [79:0] FP_ONE = 80'h3FFF_8000_0000_0000_0000;

  // Format figures
  localparam int PREC_SINGLE = 24;
  localparam int PREC_DOUBLE = 53;
  localparam int PREC_EXT = 64;
  localparam int EMAX_SINGLE = 127;
  localparam int EMAX_DOUBLE = 1023;
  localparam int EMAX_EXT = 16383;
  localparam int SIG_W = 67;

  typedef enum logic [1:0] {FMT_SINGLE = 2'b00, FMT_DOUBLE = 2'b01, FMT_EXT = 2'b10} fpc_fmt_type;
  typedef enum logic [1:0] {RM_NEAREST = 2'b00, RM_DOWN = 2'b01, RM_UP = 2'b10, RM_ZERO = 2'b11} fpc_rmode_type;
  typedef enum logic [1:0] {OPK_LOCAL = 2'b00, OPK_GLOBAL = 2'b01, OPK_FPREG = 2'b10, OPK_LITERAL = 2'b11} fpc_opkind_type;
  typedef enum logic [2:0] {
    FLT_NONE = 3'b000, FLT_RESENC = 3'b001, FLT_INVALID = 3'b010, FLT_ZDIV = 3'b011,
    FLT_OVF = 3'b100, FLT_UNF = 3'b101, FLT_INX = 3'b110, FLT_INTOVF = 3'b111
  } fpc_fault_type;

  typedef struct packed {
    fpc_opkind_type kind;
    logic [3:0] idx;
    logic [79:0] constVal;
    logic bad;
  } fpc_opnd_type;

  typedef struct packed {
    fpc_opnd_type src1;
    fpc_opnd_type src2;
    fpc_opnd_type dst;
    fpc_fmt_type genFmt;
    logic illegal;
  } fpc_decode_type;

  typedef struct packed {
    logic sign;
    logic signed [18:0] exp;
    logic [SIG_W-1:0] sig;
    logic sticky;
    fpc_fmt_type fmt;
    logic isCompare;
    logic nanRes;
    logic invalid;
    logic zeroDiv;
    logic [79:0] srcA;
    logic [79:0] srcB;
    logic [1:0] srcUsed;
  } fpc_round_req_type;

  typedef struct packed {
    logic [79:0] result;
    logic write;
    fpc_fault_type fault;
    logic [EXC_N-1:0] exc;
  } fpc_round_rsp_type;

endpackage : fpc_pkg

// *** test/fpc_core_model.sv ***
`timescale 1ns/1ps
module fpc_core_model
  import fpc_pkg::*;
(
  input wire logic clk,
  output logic decValid,
  output logic [31:0] decWord,
  output logic reqValid,
  output fpc_round_req_type req,
  output logic intOvfEvt
);
  // Quiet at time zero
  initial
  begin
    decValid = 1'b0;
    decWord = 32'h0;
    reqValid = 1'b0;
    req = '0;
    intOvfEvt = 1'b0;
  end

  // Instruction pulse; payload scrambled afterwards so a stale word never looks valid
  task send_dec(input logic [31:0] w);
    @(posedge clk);
    decValid <= 1'b1;
    decWord <= w;
    @(posedge clk);
    decValid <= 1'b0;
    decWord <= ~w;
  endtask : send_dec

  // Rounding request pulse, same scrambling
  task send_req(input fpc_round_req_type r);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= r;
    @(posedge clk);
    reqValid <= 1'b0;
    req <= ~r;
  endtask : send_req

  // Integer overflow event from the integer side
  task pulse_int();
    @(posedge clk);
    intOvfEvt <= 1'b1;
    @(posedge clk);
    intOvfEvt <= 1'b0;
  endtask : pulse_int
endmodule : fpc_core_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import fpc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, decValid, decOutValid, reqValid, rspValid, intOvfEvt, intFault;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, decWord, acwOut;
  fpc_decode_type decOut;
  fpc_round_req_type req;
  fpc_round_rsp_type rsp, e;
  int err_total = 0, total_checks = 0, cycles = 0;
  logic [15:0] lfsr = 16'hA84E;
  logic [33:0] axQ[$];
  fpc_round_rsp_type rQ[$];
  logic [59:0] dQ[$], d;
  localparam logic [66:0] ONE = 67'h1 << 66;
  localparam logic [79:0] DEN = 80'h1;
  // Rows: positive tie, negative tie, positive overflow, negative overflow; columns by mode code
  logic [31:0] tab [4][4] = '{'{32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0001, 32'h3F80_0000},
    '{32'hBF80_0000, 32'hBF80_0001, 32'hBF80_0000, 32'hBF80_0000},
    '{32'h7F80_0000, 32'h7F7F_FFFF, 32'h7F80_0000, 32'h7F7F_FFFF},
    '{32'hFF80_0000, 32'hFF80_0000, 32'hFF7F_FFFF, 32'hFF7F_FFFF}};

  always #20 clk = ~clk;

  fpc_arith_ctrl dut (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .decValid(decValid), .decWord(decWord), .decOutValid(decOutValid),
    .decOut(decOut), .reqValid(reqValid), .req(req), .rspValid(rspValid), .rsp(rsp), .intOvfEvt(intOvfEvt),
    .intFault(intFault), .acwOut(acwOut));
  fpc_core_model model (.clk(clk), .decValid(decValid), .decWord(decWord), .reqValid(reqValid), .req(req),
    .intOvfEvt(intOvfEvt));

  task check(input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task give_verdict();
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  // Operand summary; constants reduced to two flags to keep notes short
  function automatic logic [8:0] opk(input fpc_opnd_type o);
    return {o.kind, o.idx, o.bad, o.constVal === FP_ONE, o.constVal === 80'h0};
  endfunction : opk

  function automatic logic [17:0] eo(input fpc_opkind_type k, input logic [3:0] i, input logic one, input logic zero);
    return {(k == OPK_LITERAL) ? 9'h183 : 9'h1FC, k, (k == OPK_LITERAL) ? 4'h0 : i, 1'b0, one, zero};
  endfunction : eo

  function automatic logic [31:0] dw(input logic lng, input logic [2:0] m, input logic [4:0] c1, c2, cd);
    return {8'h00, cd, c2, m, 3'b000, lng, 2'b00, c1};
  endfunction : dw

  // Write: address and data offered together, each released when taken
  task axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clk);
    axQ.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, input logic [33:0] x);
    @(posedge clk);
    axQ.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task rnd(input logic [66:0] sg, input int ex, input logic s, input fpc_fmt_type f, input logic [79:0] sa,
    input logic [1:0] fl, input logic [79:0] res, input logic [4:0] x, input logic w, input fpc_fault_type ft);
    fpc_round_req_type r;
    r = '0;
    r.sig = sg;
    r.exp = ex[18:0];
    r.sign = s;
    r.fmt = f;
    r.srcA = sa;
    r.srcUsed = {1'b0, sa != 80'h0};
    r.isCompare = fl[1];
    r.nanRes = fl[0];
    rQ.push_back(fpc_round_rsp_type'{res, w, ft, x});
    model.send_req(r);
  endtask : rnd

  task dec(input logic [31:0] w, input logic [17:0] a, b, c, input fpc_fmt_type f, input logic ill);
    dQ.push_back({a[17:9], b[17:9], c[17:9], 3'b111, a[8:0], b[8:0], c[8:0], f, ill});
    model.send_dec(w);
  endtask : dec

  // Watcher: each answer against the oldest note
  always @(posedge clk)
  begin
    if (bvalid === 1'b1 && bready === 1'b1)
      check({bresp, 32'h0}, axQ.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, axQ.pop_front());
    if (rspValid === 1'b1)
    begin
      e = rQ.pop_front();
      check({rsp.write, rsp.fault, rsp.exc}, {e.write, e.fault, e.exc});
      if (e.write)
        check(rsp.result, e.result);
    end
    if (decOutValid === 1'b1)
    begin
      d = dQ.pop_front();
      check(d[59:30] & {opk(decOut.src1), opk(decOut.src2), opk(decOut.dst), decOut.genFmt, decOut.illegal},
        d[29:0]);
    end
  end

  // Hang guard, generous against the under two hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    logic [4:0] a, b, c;
    logic lng;
    int i, j;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check(acwOut, 32'h3F00_1000);
    axi_rd(4'h0, {RESP_OKAY, 32'h3F00_1000});
    axi_rd(4'h8, {RESP_SLVERR, 32'h0});
    axi_wr(4'h8, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(4'h0, 32'hFFFF_FFFF, RESP_OKAY);
    axi_rd(4'h0, {RESP_OKAY, 32'hFF1F_117F});
    // Integer overflow with its mask clear, then set
    axi_wr(4'h0, 32'h0, RESP_OKAY);
    model.pulse_int();
    #1 check(intFault, 1'b1);
    axi_rd(4'h0, {RESP_OKAY, 32'h0000_0100});
    axi_wr(4'h0, 32'h0000_1000, RESP_OKAY);
    model.pulse_int();
    #1 check(intFault, 1'b0);
    // Every rounding mode: exact, ties, overflow both signs, NaN, compare
    for (i = 0; i < 4; i++)
    begin
      axi_wr(4'h0, {i[1:0], 30'h3F00_1000}, RESP_OKAY);
      rnd(ONE, 0, 1'b0, FMT_SINGLE, 80'h0, 2'b00, 80'h3F80_0000, 5'h00, 1'b1, FLT_NONE);
      for (j = 0; j < 4; j++)
        rnd(j[1] ? ONE : ONE | (67'h1 << 42), j[1] ? 128 : 0, j[0], FMT_SINGLE, 80'h0, 2'b00, {48'h0, tab[j][i]},
          j[1] ? 5'h11 : 5'h10, 1'b1, FLT_NONE);
      rnd(ONE, 0, 1'b0, FMT_SINGLE, 80'h0, 2'b01, 80'h7FC0_0000, 5'h00, 1'b1, FLT_NONE);
      rnd(ONE, 0, 1'b0, FMT_SINGLE, 80'h0, 2'b10, 80'h0, 5'h00, 1'b0, FLT_NONE);
      axi_rd(4'h0, {RESP_OKAY, {i[1:0], 30'h3F00_1000} | 32'h0011_0000});
    end
    // Normalizing mode off: denormal source refused, denormal result still delivered
    axi_wr(4'h0, 32'h1F00_1000, RESP_OKAY);
    rnd(ONE, 0, 1'b0, FMT_SINGLE, DEN, 2'b00, 80'h0, 5'h00, 1'b0, FLT_RESENC);
    rnd(ONE, -127, 1'b0, FMT_SINGLE, 80'h0, 2'b00, 80'h0040_0000, 5'h00, 1'b1, FLT_NONE);
    axi_wr(4'h0, 32'h3E00_1000, RESP_OKAY);
    rnd(ONE, 0, 1'b0, FMT_SINGLE, DEN, 2'b00, 80'h3F80_0000, 5'h00, 1'b1, FLT_NONE);
    rnd(ONE | (67'h3 << 42), 0, 1'b0, FMT_SINGLE, 80'h0, 2'b00, 80'h3F80_0002, 5'h10, 1'b1, FLT_NONE);
    // Bits below the half point would be lost by a second rounding
    rnd(ONE | (67'h1 << 13) | 67'h1, 0, 1'b0, FMT_DOUBLE, 80'h0, 2'b00, 80'h3FF0_0000_0000_0001, 5'h10, 1'b1,
      FLT_NONE);
    rnd(ONE, 128, 1'b0, FMT_SINGLE, 80'h0, 2'b00, 80'h0, 5'h11, 1'b0, FLT_OVF);
    axi_rd(4'h4, {RESP_OKAY, 32'h4});
    axi_rd(4'h0, {RESP_OKAY, 32'h3E11_1000});
    // Decode: literals, float registers, a bad code, then random general registers
    dec(dw(1'b0, 3'b111, 5'h16, 5'h10, 5'h03), eo(OPK_LITERAL, 4'h0, 1'b1, 1'b0), eo(OPK_LITERAL, 4'h0, 1'b0, 1'b1),
      eo(OPK_FPREG, 4'h3, 1'b0, 1'b0), FMT_SINGLE, 1'b0);
    dec(dw(1'b1, 3'b101, 5'h02, 5'h04, 5'h00), eo(OPK_FPREG, 4'h2, 1'b0, 1'b0), eo(OPK_LOCAL, 4'h4, 1'b0, 1'b0),
      eo(OPK_FPREG, 4'h0, 1'b0, 1'b0), FMT_DOUBLE, 1'b0);
    dec(dw(1'b0, 3'b001, 5'h11, 5'h04, 5'h05), {9'h004, 9'h004}, 18'h0, 18'h0, FMT_SINGLE, 1'b1);
    for (i = 0; i < 8; i++)
    begin
      lfsr = nxt(lfsr);
      lng = lfsr[15];
      a = lfsr[4:0] & {4'hF, ~lng};
      b = lfsr[9:5] & {4'hF, ~lng};
      c = lfsr[14:10] & {4'hF, ~lng};
      dec(dw(lng, 3'b000, a, b, c), eo(a[4] ? OPK_GLOBAL : OPK_LOCAL, a[3:0], 1'b0, 1'b0),
        eo(b[4] ? OPK_GLOBAL : OPK_LOCAL, b[3:0], 1'b0, 1'b0), eo(c[4] ? OPK_GLOBAL : OPK_LOCAL, c[3:0], 1'b0, 1'b0),
        lng ? FMT_DOUBLE : FMT_SINGLE, 1'b0);
    end
    repeat (5) @(posedge clk);
    check(rQ.size() + dQ.size() + axQ.size(), 0);
    give_verdict();
  end
endmodule : testbench
